// ==== tb/fbg_flash_model.sv ====
// Purpose: flash array and entry port seen by the guard
// Assumes: one flash read in flight at a time
// Notes: between reads the data lines show the inverse of the last byte
`timescale 1ns/100ps
module fbg_flash_model (
    input wire logic mclk,
    input wire logic flashRdEn,
    input wire logic [23:0] flashRdAddr,
    output logic [7:0] flashRdData,
    input wire logic [15:0] portRdAddr,
    output logic [7:0] portRdData
);
    // Loaded only with defined boot descriptor combinations
    logic [7:0] mem [logic [23:0]];
    logic [7:0] portVal = 8'h00;
    logic [7:0] lastVal = 8'h00;
    logic rdPend = 1'b0;
    logic [23:0] addrQ = 24'h000000;

    // Erased cells read as all ones
    function automatic logic [7:0] byteAt(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    always @(posedge mclk)
    begin
        rdPend <= flashRdEn;
        addrQ <= flashRdAddr;
        if (rdPend)
            lastVal <= flashRdData;
    end
    assign flashRdData = rdPend ? byteAt(addrQ) : ~lastVal;
    assign portRdData = portVal;
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for boot selection and flash guard
// Assumes: partner model holds flash contents and entry port level
// Notes: each boot resets the block; flash is reloaded only by a preceding load
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic pms = 1'b0, lowPin = 1'b0, highPin = 1'b0, romProtectBit = 1'b1;
    logic idStrobe = 1'b0, cmdStrobe = 1'b0, parAccessReq = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [23:0] cpuAddr = 24'h000000;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rv;
    fbg_pkg::fbg_id_t idIn = '0;
    logic flashRdEn, decided, cmdAccept, parAccessGrant, eraseAllUserRom, secondRomEnable;
    logic dataFlashHit, sawErase = 1'b0, sawCmd = 1'b0;
    logic [23:0] flashRdAddr, fetchStart;
    logic [7:0] flashRdData, portRdData, regRdData;
    logic [15:0] portRdAddr;
    fbg_pkg::fbg_mode_t bootMode;
    fbg_pkg::fbg_verdict_t verdict;
    logic [55:0] idA = 56'h0123456789ABCD;
    int fails = 0;
    int n_checks = 0;

    always #12.5 mclk = ~mclk;

    fbg_flash_model flash (.mclk(mclk), .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr),
        .flashRdData(flashRdData), .portRdAddr(portRdAddr), .portRdData(portRdData));
    fbg_guard DUT (.mclk(mclk), .resetn(resetn), .processorModeStrap(pms),
        .bootStrapLowPin(lowPin), .bootStrapHighPin(highPin), .romProtectBit(romProtectBit),
        .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
        .portRdAddr(portRdAddr), .portRdData(portRdData), .idStrobe(idStrobe), .idIn(idIn),
        .cmdStrobe(cmdStrobe), .parAccessReq(parAccessReq), .cpuAddr(cpuAddr),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .bootMode(bootMode), .fetchStart(fetchStart),
        .decided(decided), .verdict(verdict), .cmdAccept(cmdAccept),
        .parAccessGrant(parAccessGrant), .eraseAllUserRom(eraseAllUserRom),
        .secondRomEnable(secondRomEnable), .dataFlashHit(dataFlashHit));

    // Pulses are caught here so their exact cycle does not matter
    always @(posedge mclk)
    begin
        if (eraseAllUserRom === 1'b1)
            sawErase <= 1'b1;
        if (cmdAccept === 1'b1)
            sawCmd <= 1'b1;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic load(input logic sig, input logic [31:0] desc, input logic [7:0] vec,
        input logic [55:0] id);
        flash.mem.delete();
        for (int i = 0; i < 8; i++)
            if (sig)
                flash.mem[fbg_pkg::SIG_BASE + 24'(i)] = fbg_pkg::BOOT_SIG[63-8*i -: 8];
        for (int i = 0; i < 4; i++)
        begin
            flash.mem[fbg_pkg::DESC_BASE + 24'(i)] = desc[8*i +: 8];
            flash.mem[fbg_pkg::RESET_VEC_BASE + 24'(i)] = vec;
        end
        for (int i = 0; i < 7; i++)
            flash.mem[fbg_pkg::ID_FIRST_ADDR + 24'(4*(i+(i>1)))] = id[55-8*i -: 8];
    endtask

    // Straps as {mode, low, high}; bounded wait for the scan
    task automatic boot(input logic [2:0] s);
        @(posedge mclk);
        {pms, lowPin, highPin} <= s;
        resetn <= 1'b0;
        sawErase <= 1'b0;
        sawCmd <= 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        for (int i = 0; i < 300 && decided !== 1'b1; i++)
            @(posedge mclk);
        #1;
        chk(decided, 1'b1);
    endtask

    task automatic ident(input logic [55:0] v);
        @(posedge mclk);
        idStrobe <= 1'b1;
        idIn <= {1'b1, v};
        @(posedge mclk);
        idStrobe <= 1'b0;
        cmdStrobe <= 1'b1;
        @(posedge mclk);
        cmdStrobe <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        rv = regRdData;
    endtask

    initial
    begin
        load(1'b1, 32'h0, 8'hFF, idA);
        boot(3'b111);
        chk(bootMode, fbg_pkg::FBG_MODE_NORMAL);
        rd(8'h00);
        chk(rv, 8'h01);
        chk(secondRomEnable, 1'b0);
        wr(8'h00, 8'h00);
        rd(8'h00);
        chk(secondRomEnable, 1'b1);
        cpuAddr <= 24'h00E000;
        rd(8'h01);
        chk(dataFlashHit, 1'b0);
        wr(8'h01, 8'h01);
        cpuAddr <= 24'h00FFFF;
        rd(8'h01);
        chk(dataFlashHit, 1'b1);
        cpuAddr <= 24'h010000;
        rd(8'h01);
        chk(dataFlashHit, 1'b0);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h02);
        rd(8'h01);
        chk(rv, 8'h09);
        wr(8'h01, 8'h08);
        rd(8'h01);
        chk(rv[3], 1'b1);
        wr(8'h02, 8'h00);
        rd(8'h01);
        chk(rv[3], 1'b1);
        rd(8'h10);
        chk(rv, 8'h00);
        $display("test registers done");
        boot(3'b101);
        chk(bootMode, fbg_pkg::FBG_MODE_USER_BOOT);
        chk(fetchStart, fbg_pkg::USER_BOOT_START);
        load(1'b0, 32'h0, 8'hFF, idA);
        boot(3'b101);
        chk(bootMode, fbg_pkg::FBG_MODE_SERIAL);
        flash.portVal = 8'h20;
        load(1'b1, 32'h0005_03E9, 8'hFF, idA);
        boot(3'b101);
        chk(bootMode, fbg_pkg::FBG_MODE_SERIAL);
        load(1'b1, 32'h0105_03F4, 8'hFF, idA);
        boot(3'b101);
        chk(bootMode, fbg_pkg::FBG_MODE_USER_BOOT);
        chk(portRdAddr, 16'h03F4);
        flash.portVal = 8'hDF;
        boot(3'b101);
        chk(bootMode, fbg_pkg::FBG_MODE_SERIAL);
        $display("test boot select done");
        load(1'b0, 32'h0, 8'hFF, idA);
        boot(3'b101);
        ident(~idA);
        chk({verdict.accept, sawCmd}, 2'b11);
        load(1'b0, 32'h0, 8'h00, idA);
        boot(3'b101);
        ident(idA ^ 56'h01);
        chk({verdict.reject, sawCmd}, 2'b10);
        ident(idA);
        chk({verdict.accept, sawCmd}, 2'b00);
        boot(3'b101);
        ident(idA);
        chk({verdict.accept, sawCmd}, 2'b11);
        load(1'b0, 32'h0, 8'h00, fbg_pkg::DISABLE_WORD);
        boot(3'b101);
        ident(fbg_pkg::DISABLE_WORD);
        chk({verdict.serialOff, sawCmd}, 2'b10);
        load(1'b0, 32'h0, 8'h00, fbg_pkg::ERASE_WORD);
        boot(3'b101);
        ident(fbg_pkg::ERASE_WORD);
        chk({verdict.forceErase, sawErase}, 2'b11);
        boot(3'b101);
        ident(idA);
        chk({verdict.reject, sawErase}, 2'b10);
        load(1'b0, 32'h0, 8'h00, idA);
        boot(3'b101);
        ident(fbg_pkg::ERASE_WORD);
        chk(sawErase, 1'b1);
        @(posedge mclk) romProtectBit <= 1'b0;
        boot(3'b101);
        ident(fbg_pkg::ERASE_WORD);
        chk({verdict.reject, sawErase}, 2'b10);
        load(1'b1, 32'h0, 8'h00, fbg_pkg::ERASE_WORD);
        boot(3'b101);
        ident(fbg_pkg::ERASE_WORD);
        chk(sawErase, 1'b0);
        $display("test identifier done");
        @(posedge mclk) parAccessReq <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(parAccessGrant, 1'b0);
        @(posedge mclk) romProtectBit <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(parAccessGrant, 1'b1);
        $display("test parallel guard done");
        conclude();
    end

    // About 1200 cycles expected; the limit of 20000 cycles is over sixteen times that
    initial
    begin
        #500000;
        fails++;
        conclude();
    end
endmodule

// ==== verilog/fbg_guard.sv ====
// Purpose: reset-time boot selection, region gating and serial/parallel guard
// Assumes: flash read data one cycle after flashRdEn; strap and port pins synchronous
// Notes: verdicts hold until the next reset
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
// Behaviour
// - Boot mode on reset when low strap low, mode and high straps high.
// - Eight signature bytes must match the boot signature, else serial mode.
// - Signature good and descriptor all zero selects user boot, no port sampled.
// - Otherwise sample the named port bit; level select decides its polarity.
// - Descriptor address must be one of the eleven port data registers.
// - User boot starts fetch at the second program ROM start.
// - Second program ROM usable only while its disable bit is zero.
// - Data flash mapped into its window only while select bit is one.
// - Rewrite enable forces area expand bit; writes held, applied after clearing.
// - Entering rewrite mode sets data flash select and area expand bits.
// - Protect bit zero refuses parallel programmer reads and rewrites.
// - Serial mode compares seven identifier bytes; mismatch rejects later commands.
// - Blank reset vector skips comparison and accepts every command.
// - Stored identifier read first byte first at four-byte spacing.
// - Recognise the forced-erase and serial-disable reserved words.
// - Forced erase only in serial mode when erase word is sent and also stored, or sent while unprotected.
// - Sent erase word, stored differs: erase if unprotected, else normal check.
// - Stored erase word, other sent: mismatch, ignore commands, stay protected.
// - Stored disable word refuses serial communication; user boot still allowed.
module fbg_guard (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic processorModeStrap,
    input wire logic bootStrapLowPin,
    input wire logic bootStrapHighPin,
    input wire logic romProtectBit,
    output logic flashRdEn,
    output logic [23:0] flashRdAddr,
    input wire logic [7:0] flashRdData,
    output logic [15:0] portRdAddr,
    input wire logic [7:0] portRdData,
    input wire logic idStrobe,
    input wire fbg_pkg::fbg_id_t idIn,
    input wire logic cmdStrobe,
    input wire logic parAccessReq,
    input wire logic [23:0] cpuAddr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output fbg_pkg::fbg_mode_t bootMode,
    output logic [23:0] fetchStart,
    output logic decided,
    output fbg_pkg::fbg_verdict_t verdict,
    output logic cmdAccept,
    output logic parAccessGrant,
    output logic eraseAllUserRom,
    output logic secondRomEnable,
    output logic dataFlashHit
);
    // ------------------------------------------------------------
    // Register offsets and bit positions
    // ------------------------------------------------------------
    localparam logic [7:0] REG_SECOND_ROM_CONTROL = 8'h00;
    localparam logic [7:0] REG_PROCESSOR_MODE_ONE = 8'h01;
    localparam logic [7:0] REG_FLASH_CONTROL_ZERO = 8'h02;
    localparam logic [7:0] REG_STATUS = 8'h03;
    localparam int PM_DFS = 0;
    localparam int PM_IAE = 3;
    localparam int FC_CRE = 1;

    typedef enum logic [2:0] {
        S_IDLE, S_SIG, S_DESC, S_PORT, S_VEC, S_ID, S_DONE
    } fbg_scan_t;

    fbg_scan_t scan;
    logic [3:0] idx;
    logic rdPend;
    logic [63:0] sigBuf;
    logic [31:0] descBuf;
    logic [31:0] vecBuf;
    logic [55:0] storedId;
    logic bootEntry;
    logic serialMode;
    logic secondRomDisable;
    logic dataFlashSelect;
    logic expandShadow;
    logic cpuRewriteEnable;
    logic [7:0] next_rdData;

    function automatic logic portValid(input logic [15:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < fbg_pkg::NUM_PORTS; i++)
        begin
            if (a == fbg_pkg::PORT_ADDR[i])
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Reset-time scan of boot area, vectors and identifier
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            scan <= S_IDLE;
            idx <= 4'h0;
            rdPend <= 1'b0;
            flashRdEn <= 1'b0;
            flashRdAddr <= 24'h000000;
            portRdAddr <= 16'h0000;
            sigBuf <= 64'h0000000000000000;
            descBuf <= 32'h00000000;
            vecBuf <= 32'h00000000;
            storedId <= 56'h00000000000000;
            bootEntry <= 1'b0;
            serialMode <= 1'b0;
            bootMode <= fbg_pkg::FBG_MODE_NONE;
            fetchStart <= 24'h000000;
            decided <= 1'b0;
        end
        else
        begin
            flashRdEn <= 1'b0;
            rdPend <= flashRdEn;
            case (scan)
                S_IDLE:
                begin
                    // Straps caught on the first edge after release
                    bootEntry <= !bootStrapLowPin && processorModeStrap && bootStrapHighPin;
                    scan <= S_VEC;
                    idx <= 4'h0;
                end
                S_VEC:
                begin
                    if (rdPend)
                    begin
                        vecBuf <= {flashRdData, vecBuf[31:8]};
                        idx <= idx + 4'h1;
                        if (idx == 4'h3)
                        begin
                            scan <= S_ID;
                            idx <= 4'h0;
                        end
                    end
                    else if (!flashRdEn)
                    begin
                        flashRdEn <= 1'b1;
                        flashRdAddr <= fbg_pkg::RESET_VEC_BASE + {20'h00000, idx};
                    end
                end
                S_ID:
                begin
                    if (rdPend)
                    begin
                        storedId <= {storedId[47:0], flashRdData};
                        idx <= idx + 4'h1;
                        if (idx == 4'(fbg_pkg::ID_BYTES - 1))
                        begin
                            idx <= 4'h0;
                            if (bootEntry)
                            begin
                                scan <= S_SIG;
                            end
                            else
                            begin
                                scan <= S_DONE;
                                bootMode <= fbg_pkg::FBG_MODE_NORMAL;
                                decided <= 1'b1;
                            end
                        end
                    end
                    else if (!flashRdEn)
                    begin
                        flashRdEn <= 1'b1;
                        // Slot after the second byte is skipped
                        flashRdAddr <= fbg_pkg::ID_FIRST_ADDR
                            + 24'((idx + 4'(idx > 4'h1)) * fbg_pkg::ID_STEP);
                    end
                end
                S_SIG:
                begin
                    if (rdPend)
                    begin
                        sigBuf <= {sigBuf[55:0], flashRdData};
                        idx <= idx + 4'h1;
                        if (idx == 4'h7)
                        begin
                            idx <= 4'h0;
                            scan <= S_DESC;
                        end
                    end
                    else if (!flashRdEn)
                    begin
                        flashRdEn <= 1'b1;
                        flashRdAddr <= fbg_pkg::SIG_BASE + {20'h00000, idx};
                    end
                end
                S_DESC:
                begin
                    if (sigBuf != fbg_pkg::BOOT_SIG)
                    begin
                        scan <= S_DONE;
                        serialMode <= 1'b1;
                        bootMode <= fbg_pkg::FBG_MODE_SERIAL;
                        decided <= 1'b1;
                    end
                    else if (rdPend)
                    begin
                        descBuf <= {descBuf[23:0], flashRdData};
                        idx <= idx + 4'h1;
                        if (idx == 4'h3)
                        begin
                            scan <= S_PORT;
                        end
                    end
                    else if (!flashRdEn)
                    begin
                        flashRdEn <= 1'b1;
                        flashRdAddr <= fbg_pkg::DESC_BASE + {20'h00000, idx};
                    end
                end
                S_PORT:
                begin
                    // Descriptor bytes: addr low, addr high, bit index, level select
                    scan <= S_DONE;
                    decided <= 1'b1;
                    if (descBuf == 32'h00000000)
                    begin
                        bootMode <= fbg_pkg::FBG_MODE_USER_BOOT;
                        fetchStart <= fbg_pkg::USER_BOOT_START;
                    end
                    else if (portValid({descBuf[23:16], descBuf[31:24]})
                        && descBuf[15:8] <= fbg_pkg::BIT_INDEX_MAX
                        && (descBuf[7:0] == fbg_pkg::LEVEL_HIGH_SERIAL
                        || descBuf[7:0] == fbg_pkg::LEVEL_HIGH_USER)
                        && (portRdData[descBuf[10:8]] == descBuf[0]))
                    begin
                        bootMode <= fbg_pkg::FBG_MODE_USER_BOOT;
                        fetchStart <= fbg_pkg::USER_BOOT_START;
                    end
                    else
                    begin
                        // Undefined descriptors fall back to serial, the safe mode
                        serialMode <= 1'b1;
                        bootMode <= fbg_pkg::FBG_MODE_SERIAL;
                    end
                end
                S_DONE:
                begin
                    scan <= S_DONE;
                end
                default:
                begin
                    scan <= S_IDLE;
                end
            endcase
            if (scan == S_DESC && rdPend && idx == 4'h1)
            begin
                portRdAddr <= {flashRdData, descBuf[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Identifier verdict, held until reset
    // ------------------------------------------------------------
    logic blankVec;
    logic sentErase;
    logic storedErase;
    assign blankVec = (vecBuf == fbg_pkg::BLANK_VECTOR);
    assign sentErase = (idIn.id == fbg_pkg::ERASE_WORD);
    assign storedErase = (storedId == fbg_pkg::ERASE_WORD);

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            verdict <= '0;
            eraseAllUserRom <= 1'b0;
        end
        else if (decided && serialMode && !verdict.accept && !verdict.reject
            && !verdict.serialOff)
        begin
            if (storedId == fbg_pkg::DISABLE_WORD)
            begin
                verdict.serialOff <= 1'b1;
                verdict.reject <= 1'b1;
            end
            else if (blankVec)
            begin
                verdict.accept <= 1'b1;
            end
            else if (idStrobe && idIn.idValid)
            begin
                if (sentErase && (storedErase || romProtectBit))
                begin
                    verdict.forceErase <= 1'b1;
                    verdict.accept <= 1'b1;
                    eraseAllUserRom <= 1'b1;
                end
                else if (idIn.id == storedId)
                begin
                    verdict.accept <= 1'b1;
                end
                else
                begin
                    verdict.reject <= 1'b1;
                end
            end
        end
        else
        begin
            eraseAllUserRom <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            cmdAccept <= 1'b0;
            parAccessGrant <= 1'b0;
        end
        else
        begin
            cmdAccept <= cmdStrobe && verdict.accept && serialMode;
            parAccessGrant <= parAccessReq && romProtectBit;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            secondRomDisable <= fbg_pkg::RST_SECOND_ROM_DISABLE;
            dataFlashSelect <= fbg_pkg::RST_DATA_FLASH_SELECT;
            expandShadow <= fbg_pkg::RST_INTERNAL_AREA_EXPAND;
            cpuRewriteEnable <= fbg_pkg::RST_CPU_REWRITE_ENABLE;
        end
        else if (regWr)
        begin
            case (regAddr)
                REG_SECOND_ROM_CONTROL: secondRomDisable <= regWrData[0];
                REG_PROCESSOR_MODE_ONE:
                begin
                    dataFlashSelect <= regWrData[PM_DFS];
                    expandShadow <= regWrData[PM_IAE];
                end
                REG_FLASH_CONTROL_ZERO:
                begin
                    cpuRewriteEnable <= regWrData[FC_CRE];
                    if (regWrData[FC_CRE] && !cpuRewriteEnable)
                    begin
                        dataFlashSelect <= 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    logic areaExpand;
    assign areaExpand = cpuRewriteEnable | expandShadow;

    always_comb
    begin
        case (regAddr)
            REG_SECOND_ROM_CONTROL: next_rdData = {7'h00, secondRomDisable};
            REG_PROCESSOR_MODE_ONE: next_rdData = {4'h0, areaExpand, 2'h0, dataFlashSelect};
            REG_FLASH_CONTROL_ZERO: next_rdData = {6'h00, cpuRewriteEnable, 1'b0};
            REG_STATUS: next_rdData = {2'h0, verdict, decided, serialMode};
            default: next_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            regRdData <= 8'h00;
            secondRomEnable <= 1'b0;
            dataFlashHit <= 1'b0;
        end
        else
        begin
            regRdData <= regRd ? next_rdData : 8'h00;
            secondRomEnable <= !secondRomDisable;
            dataFlashHit <= dataFlashSelect && cpuAddr >= fbg_pkg::DFLASH_LO
                && cpuAddr <= fbg_pkg::DFLASH_HI;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_par_refused: assert property (@(posedge mclk) disable iff (!resetn)
        parAccessReq && !romProtectBit |=> !parAccessGrant)
        else $error("parallel access granted while protected");
    a_cmd_rejected: assert property (@(posedge mclk) disable iff (!resetn)
        verdict.reject |=> !cmdAccept)
        else $error("command accepted after mismatch");
    a_verdict_held: assert property (@(posedge mclk) disable iff (!resetn)
        verdict.accept |=> verdict.accept)
        else $error("verdict changed before reset");
    a_user_fetch: assert property (@(posedge mclk) disable iff (!resetn)
        bootMode == fbg_pkg::FBG_MODE_USER_BOOT |-> fetchStart == fbg_pkg::USER_BOOT_START)
        else $error("user boot fetch start wrong");
    a_bad_sig: assert property (@(posedge mclk) disable iff (!resetn)
        scan == S_DESC && sigBuf != fbg_pkg::BOOT_SIG |=> bootMode == fbg_pkg::FBG_MODE_SERIAL)
        else $error("bad signature did not select serial");
    a_rewrite_expand: assert property (@(posedge mclk) disable iff (!resetn)
        cpuRewriteEnable |-> next_rdData[PM_IAE] || regAddr != REG_PROCESSOR_MODE_ONE)
        else $error("area expand not forced");
    a_rewrite_dfs: assert property (@(posedge mclk) disable iff (!resetn)
        regWr && regAddr == REG_FLASH_CONTROL_ZERO && regWrData[FC_CRE] && !cpuRewriteEnable
        |=> dataFlashSelect)
        else $error("data flash select not set on rewrite entry");
    a_rom2_gate: assert property (@(posedge mclk) disable iff (!resetn)
        secondRomDisable ##1 secondRomDisable |-> !secondRomEnable)
        else $error("second rom enabled while disabled");
    a_df_gate: assert property (@(posedge mclk) disable iff (!resetn)
        !dataFlashSelect |=> !dataFlashHit)
        else $error("data flash hit while deselected");
    a_serial_off: assert property (@(posedge mclk) disable iff (!resetn)
        verdict.serialOff |-> !verdict.accept)
        else $error("serial accepted while disabled");
    c_user_boot: cover property (@(posedge mclk) bootMode == fbg_pkg::FBG_MODE_USER_BOOT);
    c_serial: cover property (@(posedge mclk) verdict.accept && serialMode);
    c_force: cover property (@(posedge mclk) eraseAllUserRom);
    c_reject: cover property (@(posedge mclk) verdict.reject);
endmodule

// ==== verilog/fbg_pkg.sv ====
// Purpose: constants and carriers for the flash boot select and guard block
// Assumes: byte-wide flash read port, one system clock
// Notes: addresses are byte addresses of the flash/SFR space
package fbg_pkg;
    // ------------------------------------------------------------
    // Boot code area
    // ------------------------------------------------------------
    localparam logic [23:0] SIG_BASE = 24'h013FF0;
    localparam logic [23:0] DESC_BASE = 24'h013FF8;
    localparam logic [23:0] USER_BOOT_START = 24'h010000;
    localparam logic [63:0] BOOT_SIG = 64'h55736572426F6F74;
    localparam logic [7:0] LEVEL_HIGH_SERIAL = 8'h00;
    localparam logic [7:0] LEVEL_HIGH_USER = 8'h01;
    localparam logic [7:0] BIT_INDEX_MAX = 8'h07;
    // ------------------------------------------------------------
    // Port data register addresses, first to last
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 11;
    localparam logic [15:0] PORT_ADDR [NUM_PORTS] = '{16'h03E0, 16'h03E1, 16'h03E4,
        16'h03E5, 16'h03E8, 16'h03E9, 16'h03EC, 16'h03ED, 16'h03F0, 16'h03F1, 16'h03F4};
    // ------------------------------------------------------------
    // Vector area and identifier
    // ------------------------------------------------------------
    localparam logic [23:0] RESET_VEC_BASE = 24'h0FFFFC;
    localparam logic [23:0] ID_FIRST_ADDR = 24'h0FFFDF;
    localparam logic [23:0] ID_STEP = 24'h000004;
    localparam int ID_BYTES = 7;
    localparam logic [55:0] ERASE_WORD = 56'h414C6552415345;
    localparam logic [55:0] DISABLE_WORD = 56'h50726F74656374;
    localparam logic [31:0] BLANK_VECTOR = 32'hFFFFFFFF;
    // ------------------------------------------------------------
    // Data flash window and reset values
    // ------------------------------------------------------------
    localparam logic [23:0] DFLASH_LO = 24'h00E000;
    localparam logic [23:0] DFLASH_HI = 24'h00FFFF;
    localparam logic RST_SECOND_ROM_DISABLE = 1'b1;
    localparam logic RST_DATA_FLASH_SELECT = 1'b0;
    localparam logic RST_INTERNAL_AREA_EXPAND = 1'b0;
    localparam logic RST_CPU_REWRITE_ENABLE = 1'b0;

    typedef enum logic [1:0] {
        FBG_MODE_NONE,
        FBG_MODE_NORMAL,
        FBG_MODE_USER_BOOT,
        FBG_MODE_SERIAL
    } fbg_mode_t;

    typedef struct packed {
        logic idValid;
        logic [55:0] id;
    } fbg_id_t;

    typedef struct packed {
        logic accept;
        logic reject;
        logic forceErase;
        logic serialOff;
    } fbg_verdict_t;
endpackage
